// >>> core/secure_virtual_xlate_request_regs.sv
// secure virtual translate request register bank with walker handshake
`timescale 1ns/1ps
module secure_virtual_xlate_request_regs
  import vxlate_pkg::*;
#(
  parameter int          STREAM_SIZE    = 32,
  parameter int          SUBCTX_SIZE    = 20,
  parameter bit          VXLATE_PRESENT = 1'b1,
  parameter bit          SECVIRT_PRESENT = 1'b1
) (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire reg_req_s    reg_req,
  output logic             rsp_valid,
  output logic [63:0]      rsp_rdata,
  input  wire logic        secure_unit_enable,
  output logic             walk_req_valid,
  output walk_req_s        walk_req,
  input  wire logic        walk_req_ready,
  input  wire logic        walk_done,
  input  wire logic [63:0] walk_result,
  output logic             busy
);

  localparam bit PRESENT = VXLATE_PRESENT && SECVIRT_PRESENT;

  // stored bits; source and request fields have no defined reset value
  logic         go_r;
  logic [63:0]  source_r;
  logic [63:0]  request_r;
  logic [63:0]  result_r;
  xlate_state_e state_r;
  xlate_state_e state_nxt;
  logic         rsp_valid_r;
  logic [63:0]  rsp_rdata_r;
  logic         walk_req_valid_r;
  walk_req_s    walk_req_r;

  // write masks built once from the supported sizes
  logic [63:0]  stream_mask;
  logic [63:0]  subctx_mask;
  logic [63:0]  source_mask;
  logic [63:0]  source_view;
  logic [63:0]  request_view;

  logic         wr_ok;
  logic         wr_control;
  logic         wr_source;
  logic         wr_request;
  logic         go_start;
  logic         type_bad;
  logic [63:0]  rd_data;

  always_comb begin
    stream_mask = '0;
    subctx_mask = '0;
    for (int i = 0; i < STREAM_MAX; i++) begin
      stream_mask[STREAM_LSB + i] = (i < STREAM_SIZE);
    end
    for (int j = 0; j < SUBCTX_MAX; j++) begin
      subctx_mask[SUBCTX_LSB + j] = (j < SUBCTX_SIZE);
    end
  end

  // bits 63:54 never stored; valid flag only with sub-context support
  assign source_mask = stream_mask | subctx_mask
                     | ({63'h0, (SUBCTX_SIZE != 0)} << SUBCTX_VBIT);
  assign source_view = (source_r & source_mask)
                     | (64'h1 << SECURE_BIT);
  assign request_view = request_r & REQUEST_MASK;

  // register writes: secure only, and never while a request runs
  assign wr_ok      = PRESENT && reg_req.valid && reg_req.write
                    && reg_req.secure && !go_r;
  assign wr_control = wr_ok && (reg_req.addr == OFS_CONTROL);
  assign wr_source  = wr_ok && (reg_req.addr == OFS_SOURCE);
  assign wr_request = wr_ok && (reg_req.addr == OFS_REQUEST);
  // starting without the unit enabled is refused rather than run blind
  assign go_start   = wr_control && reg_req.wdata[GO_BIT]
                    && secure_unit_enable;
  assign type_bad   = request_r[TYPE_LSB +: 2] != TYPE_STAGE1;

  // go bit: set by software, cleared by the unit after posting
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      go_r <= CONTROL_RST[GO_BIT];
    end else if (ce) begin
      if (state_r == ST_POST) begin
        go_r <= 1'b0;
      end else if (wr_control) begin
        go_r <= go_start;
      end
    end
  end

  // source ids and request hold whatever software loads
  always_ff @(posedge clk_sys) begin
    if (ce) begin
      if (wr_source) begin
        source_r <= reg_req.wdata & source_mask;
      end
      if (wr_request) begin
        request_r <= reg_req.wdata & REQUEST_MASK;
      end
    end
  end

  // request sequencer; one request in flight
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (go_r) begin
          state_nxt = type_bad ? ST_POST : ST_ISSUE;
        end
      end
      ST_ISSUE: begin
        if (walk_req_ready) begin
          state_nxt = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (walk_done) begin
          state_nxt = ST_POST;
        end
      end
      ST_POST: begin
        state_nxt = ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_r <= ST_IDLE;
    end else if (ce) begin
      state_r <= state_nxt;
    end
  end

  // latch the request for the walker when the sequence leaves idle for the issue step
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      walk_req_valid_r <= 1'b0;
      walk_req_r       <= '0;
    end else if (ce) begin
      if (state_r == ST_IDLE && go_r && !type_bad) begin
        walk_req_valid_r             <= 1'b1;
        walk_req_r.stream            <= source_view[31:0];
        walk_req_r.subctx            <= source_view[51:32];
        walk_req_r.subctx_valid      <= source_view[SUBCTX_VBIT];
        walk_req_r.page              <= request_view[63:12];
        walk_req_r.privileged        <= request_r[PRIV_BIT];
        walk_req_r.is_read           <= request_r[DIR_BIT];
        // writes always count as data accesses
        walk_req_r.is_fetch          <= request_r[DIR_BIT]
                                      & request_r[FETCH_BIT];
        walk_req_r.flag_update_block <= request_r[FLAGBLK_BIT];
      end else if (walk_req_valid_r && walk_req_ready) begin
        walk_req_valid_r <= 1'b0;
      end
    end
  end

  // result posting; stage-1 only, so fault class and fault address are zero
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      result_r <= RESULT_RST;
    end else if (ce) begin
      if (state_r == ST_IDLE && go_r && type_bad) begin
        result_r <= ({48'h0, BAD_REQ_CODE, 8'h0} >> (8 - CODE_LSB))
                  | 64'h1;
      end else if (state_r == ST_WAIT && walk_done) begin
        if (walk_result[FAULT_BIT]) begin
          result_r <= walk_result & FAULT_KEEP;
        end else begin
          result_r <= walk_result;
        end
      end
    end
  end

  // read mux; the result is readable while busy but not meaningful then
  always_comb begin
    rd_data = '0;
    if (PRESENT && reg_req.secure) begin
      case (reg_req.addr)
        OFS_CONTROL: rd_data = {63'h0, go_r};
        OFS_SOURCE:  rd_data = source_view;
        OFS_REQUEST: rd_data = request_view;
        OFS_RESULT:  rd_data = result_r;
        default:     rd_data = '0;
      endcase
    end
  end

  // read answer one cycle after the request
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rsp_valid_r <= 1'b0;
      rsp_rdata_r <= '0;
    end else if (ce) begin
      rsp_valid_r <= reg_req.valid && !reg_req.write;
      rsp_rdata_r <= rd_data;
    end
  end

  assign rsp_valid      = rsp_valid_r;
  assign rsp_rdata      = rsp_rdata_r;
  assign walk_req_valid = walk_req_valid_r;
  assign walk_req       = walk_req_r;
  assign busy           = go_r;

  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // post step only counts on an enabled edge, where the clear really lands
  sequence s_post;
    ce && state_r == ST_POST;
  endsequence

  sequence s_done;
    ce && state_r == ST_WAIT && walk_done;
  endsequence

  sequence s_go_clear;
    ##1 !go_r;
  endsequence

  property p_go_reset;
    $fell(rst) |-> !go_r;
  endproperty
  a_go_reset: assert property (p_go_reset) else $error("go not zero after reset");

  property p_idle_reset;
    $fell(rst) |-> !walk_req_valid_r && !rsp_valid_r && state_r == ST_IDLE;
  endproperty
  a_idle_reset: assert property (p_idle_reset) else $error("walker side not idle after reset");

  property p_clear_after_post;
    s_post |-> s_go_clear;
  endproperty
  a_clear_after_post: assert property (p_clear_after_post) else $error("go not cleared");

  // the result lands while go still reads one, so software never sees stale data
  property p_result_first;
    s_done |=> go_r;
  endproperty
  a_result_first: assert property (p_result_first) else $error("go cleared before result");

  property p_success_posted;
    s_done ##0 !walk_result[FAULT_BIT] |=> result_r == $past(walk_result);
  endproperty
  a_success_posted: assert property (p_success_posted) else $error("result not posted");

  property p_go_needs_enable;
    $rose(go_r) |-> $past(secure_unit_enable) && $past(reg_req.secure);
  endproperty
  a_go_needs_enable: assert property (p_go_needs_enable) else $error("go set unguarded");

  property p_no_early_clear;
    $fell(go_r) && !$past(rst) |-> $past(state_r) == ST_POST;
  endproperty
  a_no_early_clear: assert property (p_no_early_clear) else $error("go cleared early");

  property p_ns_write_ignored;
    ce && reg_req.valid && reg_req.write && !reg_req.secure && state_r == ST_IDLE
      |=> $stable(source_r) && $stable(request_r) && $stable(go_r);
  endproperty
  a_ns_write_ignored: assert property (p_ns_write_ignored) else $error("ns write took");

  property p_ns_read_zero;
    ce && reg_req.valid && !reg_req.write && !reg_req.secure |=> rsp_rdata == 64'h0;
  endproperty
  a_ns_read_zero: assert property (p_ns_read_zero) else $error("ns read not zero");

  property p_guard_busy;
    ce && go_r && state_r != ST_POST |=> $stable(source_r) && $stable(request_r);
  endproperty
  a_guard_busy: assert property (p_guard_busy) else $error("write while busy");

  property p_secure_write;
    ce && reg_req.valid && reg_req.write && reg_req.secure && !go_r
      && reg_req.addr == OFS_REQUEST |=> request_r == ($past(reg_req.wdata) & REQUEST_MASK);
  endproperty
  a_secure_write: assert property (p_secure_write) else $error("secure write lost");

  property p_bit53;
    ce && reg_req.valid && !reg_req.write && reg_req.secure
      && reg_req.addr == OFS_SOURCE |=> rsp_rdata[SECURE_BIT] && rsp_rdata[63:54] == 10'h0;
  endproperty
  a_bit53: assert property (p_bit53) else $error("source bits wrong");

  property p_bad_type;
    ce && state_r == ST_IDLE && go_r && type_bad
      |=> result_r[FAULT_BIT] && result_r[2:1] == 2'h0 && state_r == ST_POST ##1 !go_r;
  endproperty
  a_bad_type: assert property (p_bad_type) else $error("bad type not faulted");

  property p_reason_zero;
    result_r[FAULT_BIT] |-> result_r[2:0] == 3'h1;
  endproperty
  a_reason_zero: assert property (p_reason_zero) else $error("fault class nonzero");

  property p_one_flight;
    walk_req_valid_r |-> state_r == ST_ISSUE || state_r == ST_WAIT;
  endproperty
  a_one_flight: assert property (p_one_flight) else $error("request outside flight");

  property p_write_is_data;
    walk_req_valid_r && !walk_req_r.is_read |-> !walk_req_r.is_fetch;
  endproperty
  a_write_is_data: assert property (p_write_is_data) else $error("write marked fetch");

  property p_block_passed;
    ce && state_r == ST_IDLE && go_r && !type_bad
      |=> walk_req_valid_r && walk_req_r.flag_update_block == $past(request_r[FLAGBLK_BIT]);
  endproperty
  a_block_passed: assert property (p_block_passed) else $error("flag block lost");

endmodule : secure_virtual_xlate_request_regs

// >>> core/vxlate_pkg.sv
// shared constants and carriers for the secure virtual translate request registers
package vxlate_pkg;

  // register byte offsets
  localparam logic [11:0] OFS_CONTROL = 12'hA00;
  localparam logic [11:0] OFS_SOURCE  = 12'hA08;
  localparam logic [11:0] OFS_REQUEST = 12'hA10;
  localparam logic [11:0] OFS_RESULT  = 12'hA18;

  // control register layout
  localparam int          GO_BIT       = 0;
  localparam logic [31:0] CONTROL_RST  = 32'h0000_0000;

  // source-identifier layout
  localparam int          STREAM_LSB   = 0;
  localparam int          SUBCTX_LSB   = 32;
  localparam int          SUBCTX_MAX   = 20;
  localparam int          SUBCTX_VBIT  = 52;
  localparam int          SECURE_BIT   = 53;
  localparam int          STREAM_MAX   = 32;

  // request register layout
  localparam int          PAGE_LSB     = 12;
  localparam int          TYPE_LSB     = 10;
  localparam int          PRIV_BIT     = 9;
  localparam int          DIR_BIT      = 8;
  localparam int          FETCH_BIT    = 7;
  localparam int          FLAGBLK_BIT  = 6;
  localparam logic [63:0] REQUEST_MASK = 64'hFFFF_FFFF_FFFF_FFC0;
  localparam logic [1:0]  TYPE_STAGE1  = 2'h1;

  // result register layout
  localparam int          FAULT_BIT    = 0;
  localparam int          CODE_LSB     = 3;
  localparam logic [63:0] FAULT_KEEP   = 64'h7800_0000_0000_07F9;
  localparam logic [7:0]  BAD_REQ_CODE = 8'h01;
  localparam logic [63:0] RESULT_RST   = 64'h0000_0000_0000_0000;

  // register access from the host unit
  typedef struct packed {
    logic        valid;
    logic        write;
    logic        secure;
    logic [11:0] addr;
    logic [63:0] wdata;
  } reg_req_s;

  // request as seen by the translation walker
  typedef struct packed {
    logic [31:0] stream;
    logic [19:0] subctx;
    logic        subctx_valid;
    logic [51:0] page;
    logic        privileged;
    logic        is_read;
    logic        is_fetch;
    logic        flag_update_block;
  } walk_req_s;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_ISSUE = 2'b01,
    ST_WAIT  = 2'b10,
    ST_POST  = 2'b11
  } xlate_state_e;

endpackage : vxlate_pkg

// >>> sim/tb.sv
// self-checking bench for the secure virtual translate request registers
`timescale 1ns/1ps
module tb import vxlate_pkg::*;;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic        ce = 1'b1;
  reg_req_s    reg_req = '0;
  logic        rsp_valid;
  logic [63:0] rsp_rdata;
  logic        secure_unit_enable = 1'b0;
  logic        walk_req_valid;
  walk_req_s   walk_req;
  logic        walk_req_ready = 1'b0;
  logic        walk_done = 1'b0;
  logic [63:0] walk_result = '0;
  logic        busy;
  int          mismatches = 0;
  int          num_checks = 0;
  int          cycles = 0;
  logic [63:0] rd;

  secure_virtual_xlate_request_regs DUT (
    .clk_sys            (clk_sys),
    .rst                (rst),
    .ce                 (ce),
    .reg_req            (reg_req),
    .rsp_valid          (rsp_valid),
    .rsp_rdata          (rsp_rdata),
    .secure_unit_enable (secure_unit_enable),
    .walk_req_valid     (walk_req_valid),
    .walk_req           (walk_req),
    .walk_req_ready     (walk_req_ready),
    .walk_done          (walk_done),
    .walk_result        (walk_result),
    .busy               (busy)
  );

  // 100 ns clock
  always #50 clk_sys = ~clk_sys;

  // hang guard, the whole run needs well under a thousand cycles
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      mismatches++;
      stop_test();
    end
  end

  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input string what, input logic [127:0] got, input logic [127:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // one access from a falling edge; idle cycle after so valid never re-rises in one step
  task automatic acc(input logic wr, input logic sec, input logic [11:0] a,
                     input logic [63:0] d);
    reg_req <= '{valid: 1'b1, write: wr, secure: sec, addr: a, wdata: d};
    @(negedge clk_sys);
    reg_req.valid <= 1'b0;
    rd = rsp_rdata;
    chk("rsp_valid", 128'(rsp_valid), 128'(!wr));
    @(negedge clk_sys);
  endtask : acc

  task automatic t_reset;
    acc(1'b0, 1'b1, OFS_CONTROL, '0);
    chk("control", 128'(rd), 128'h0);
    acc(1'b1, 1'b1, OFS_CONTROL, 64'h0);
    acc(1'b0, 1'b1, OFS_CONTROL, '0);
    chk("control", 128'(rd), 128'h0);
    chk("busy", 128'(busy), 128'h0);
    $display("test reset done");
  endtask : t_reset

  task automatic t_fields;
    acc(1'b1, 1'b1, OFS_SOURCE, '1);
    acc(1'b0, 1'b1, OFS_SOURCE, '0);
    chk("source", 128'(rd), 128'h003F_FFFF_FFFF_FFFF);
    acc(1'b1, 1'b1, OFS_SOURCE, '0);
    acc(1'b0, 1'b1, OFS_SOURCE, '0);
    chk("source", 128'(rd), 128'h0020_0000_0000_0000);
    acc(1'b1, 1'b1, OFS_REQUEST, '1);
    acc(1'b0, 1'b1, OFS_REQUEST, '0);
    chk("request", 128'(rd), 128'hFFFF_FFFF_FFFF_FFC0);
    // go with the unit disabled stays low
    acc(1'b1, 1'b1, OFS_CONTROL, '1);
    chk("busy", 128'(busy), 128'h0);
    $display("test fields done");
  endtask : t_fields

  task automatic t_nonsec;
    secure_unit_enable <= 1'b1;
    acc(1'b1, 1'b1, OFS_SOURCE, 64'h5);
    acc(1'b1, 1'b0, OFS_SOURCE, 64'hA);
    acc(1'b0, 1'b1, OFS_SOURCE, '0);
    chk("source", 128'(rd), 128'h0020_0000_0000_0005);
    acc(1'b0, 1'b0, OFS_SOURCE, '0);
    chk("source ns", 128'(rd), 128'h0);
    acc(1'b0, 1'b0, OFS_REQUEST, '0);
    chk("request ns", 128'(rd), 128'h0);
    acc(1'b1, 1'b0, OFS_CONTROL, 64'h1);
    chk("busy", 128'(busy), 128'h0);
    acc(1'b0, 1'b1, 12'hA30, '0);
    chk("unmapped", 128'(rd), 128'h0);
    $display("test non-secure done");
  endtask : t_nonsec

  task automatic t_walk(input logic [63:0] req, input logic [63:0] res,
                        input logic [63:0] exp_res);
    walk_req_s e;
    e = '{stream: 32'h42, subctx: 20'h3, subctx_valid: 1'b1, page: req[63:12],
          privileged: req[9], is_read: req[8], is_fetch: req[8] & req[7],
          flag_update_block: req[6]};
    // ids and request first, go last, with the unit enabled
    acc(1'b1, 1'b1, OFS_SOURCE, 64'h0010_0003_0000_0042);
    acc(1'b1, 1'b1, OFS_REQUEST, req);
    acc(1'b1, 1'b1, OFS_CONTROL, 64'h1);
    chk("busy", 128'(busy), 128'h1);
    // writes while in flight must all bounce
    acc(1'b1, 1'b1, OFS_SOURCE, '0);
    acc(1'b1, 1'b1, OFS_REQUEST, '0);
    acc(1'b0, 1'b1, OFS_REQUEST, '0);
    chk("request", 128'(rd), 128'(req & REQUEST_MASK));
    acc(1'b0, 1'b1, OFS_SOURCE, '0);
    chk("source", 128'(rd), 128'h0030_0003_0000_0042);
    acc(1'b0, 1'b1, OFS_CONTROL, '0);
    chk("control", 128'(rd), 128'h1);
    chk("walk valid", 128'(walk_req_valid), 128'h1);
    chk("walk req", 128'(walk_req), 128'(e));
    walk_req_ready <= 1'b1;
    @(negedge clk_sys);
    walk_req_ready <= 1'b0;
    chk("walk valid", 128'(walk_req_valid), 128'h0);
    walk_result <= res;
    walk_done <= 1'b1;
    @(negedge clk_sys);
    walk_done <= 1'b0;
    chk("busy", 128'(busy), 128'h1);
    for (int i = 0; i < 20 && busy !== 1'b0; i++) @(negedge clk_sys);
    chk("busy", 128'(busy), 128'h0);
    acc(1'b0, 1'b1, OFS_RESULT, '0);
    chk("result", 128'(rd), 128'(exp_res));
    chk("walk valid", 128'(walk_req_valid), 128'h0);
    $display("test walk done");
  endtask : t_walk

  task automatic t_badtype;
    logic seen;
    for (int t = 0; t < 4; t++) begin
      if (t != 1) begin
        seen = 1'b0;
        acc(1'b1, 1'b1, OFS_REQUEST, 64'h1000 | (64'(t) << 10));
        acc(1'b1, 1'b1, OFS_CONTROL, 64'h1);
        for (int i = 0; i < 20 && busy !== 1'b0; i++) begin
          seen |= walk_req_valid;
          @(negedge clk_sys);
        end
        chk("walk valid", 128'(seen), 128'h0);
        acc(1'b0, 1'b1, OFS_RESULT, '0);
        chk("result", 128'(rd), 128'((64'(BAD_REQ_CODE) << 3) | 64'h1));
      end
    end
    $display("test bad type done");
  endtask : t_badtype

  // main sequence, reset held five cycles
  initial begin
    repeat (5) @(posedge clk_sys);
    @(negedge clk_sys);
    rst <= 1'b0;
    @(negedge clk_sys);
    t_reset();
    t_fields();
    t_nonsec();
    t_walk(64'h0000_00AB_CDEF_17C0, 64'h0000_1234_5678_9000, 64'h0000_1234_5678_9000);
    t_walk(64'hFFFF_0000_0000_0480, 64'hFFFF_FFFF_FFFF_FFFF, 64'h7800_0000_0000_07F9);
    t_badtype();
    stop_test();
  end
endmodule : tb
